/* common/mei_pkg.sv */
package mei_pkg;
  // Clock rate and line timing, in their own units.
  localparam int CLK_MHZ = 200;
  localparam int BIT_NS = 100;
  localparam int MID_MIN_NS = 75;
  localparam int EOF_NS = 150;
  localparam int RXC_HIGH_NS = 50;
  localparam int SQ_GAP_NS = 150;
  localparam int COL_HOLD_NS = 200;
  // Least times round up, longest times round down.
  localparam logic [7:0] MID_MIN_CYC = 8'((MID_MIN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] EOF_CYC = 8'((EOF_NS * CLK_MHZ) / 1000);
  localparam logic [7:0] RXC_HIGH_CYC = 8'((RXC_HIGH_NS * CLK_MHZ) / 1000);
  localparam logic [7:0] SQ_GAP_CYC = 8'((SQ_GAP_NS * CLK_MHZ) / 1000);
  localparam logic [7:0] COL_HOLD_CYC = 8'((COL_HOLD_NS * CLK_MHZ) / 1000);
  localparam logic [7:0] CNT_SAT = 8'hFF;
  localparam logic [7:0] CNT_ONE = 8'h01;
  // Edge counts that qualify squelch and collision.
  localparam logic [2:0] SQ_EDGES = 3'h4;
  localparam logic [2:0] COL_EDGES = 3'h2;
  localparam logic [2:0] EDGE_ONE = 3'h1;
  // Structure sizes.
  localparam int FIFO_DEPTH = 32;
  localparam int SYNC_W = 11;
  // Values after reset, and the two valid receive-pair levels.
  localparam logic TXC_RST = 1'b0;
  localparam logic LINE_POS_RST = 1'b1;
  localparam logic LINE_NEG_RST = 1'b0;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_LOW = 2'h1;

  // One transmit word: the NRZ bit and a flag marking the frame's last bit.
  typedef struct packed {
    logic bit_val;
    logic last;
  } mei_txw_t;

  // MAC-side receive group.
  typedef struct packed {
    logic clk;
    logic data;
    logic carrier;
    logic collision;
  } mei_rx_t;

  typedef enum logic [4:0] {
    ENC_IDLE = 5'h01,
    ENC_FIRST = 5'h02,
    ENC_SECOND = 5'h04,
    ENC_TAIL = 5'h08,
    ENC_FLUSH = 5'h10
  } mei_enc_t;
endpackage

/* logic/mei_top.sv */
`timescale 1ns/10ps
// Functional notes
// - The codec bypass strap selects the internal codec at 0 and an external codec at 1.
// - With the internal codec, the MAC-codec signals are wired inside and copied to pins.
// - With the external codec, the internal codec is bypassed and MAC signals go to pins.
// - The encoder starts when the MAC sends and runs while the MAC keeps sending.
// - Each cell carries the inverted bit first and the true bit second.
// - A transmission ends with a positive-going transition, mid-cell for 1, cell end for 0.
// - Idle strap low holds the positive line above the negative; high holds them equal.
// - The decoder starts only after the input passes squelch qualification.
// - End of a received frame is found within one and a half bit times after the last bit.
// - A 10 MHz collision signal gives a steady active collision indication.
// - On collision the transmission in progress is aborted for the MAC to retry.
// - The oscillator input is divided by two to form the transmit bit clock.
// - Encoder timing comes from the oscillator; decoder timing is counted in system clock cycles.

// Three-stage input synchroniser; a change is taken once stages two and three agree.
module mei_sync #(
  parameter int W = 1
) (
  input logic clk_i, // System clock.
  input logic rst_i, // Synchronous reset.
  input logic [W-1:0] d_i, // Asynchronous inputs.
  output logic [W-1:0] q_o // Filtered levels.
);
  logic [W-1:0] s1, s2, s3;

  // Bitwise agreement keeps a one-cycle glitch in stage two from reaching the logic.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q_o <= '0;
    end
    else
    begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      q_o <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & q_o);
    end
  end
endmodule

// Word FIFO with registered full and empty flags.
module mei_fifo #(
  parameter int W = 2,
  parameter int DEPTH = 32
) (
  input logic clk_i, // System clock.
  input logic rst_i, // Synchronous reset.
  input logic [W-1:0] in_data_i, // Word to store.
  input logic in_valid_i, // Word offered.
  output logic in_ready_o, // Room for a word.
  output logic [W-1:0] out_data_o, // Oldest word.
  output logic out_valid_o, // Oldest word present.
  input logic out_ready_i // Oldest word taken.
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data_o = mem[rd_ptr];

  // Flags are registered from the next count so both sides see them without a comb path.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      count <= next_count;
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      in_ready_o <= next_count != (AW+1)'(DEPTH);
      out_valid_o <= next_count != '0;
    end
  end

  // Storage has no reset; it is read only where the count says a word is there.
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

module mei_top (
  input logic SYS_CLK_I, // 200 MHz system clock.
  input logic SYS_RST_I, // Synchronous reset, active high.
  input logic CODEC_BYPASS_STRAP_I, // Strap: 0 internal codec, 1 external codec.
  input logic IDLE_LEVEL_STRAP_I, // Strap: 0 offset idle, 1 equal idle.
  input logic OSCILLATOR_INPUT_I, // 20 MHz oscillator.
  output logic OSCILLATOR_OUTPUT_O, // Inverted oscillator feedback.
  input mei_pkg::mei_txw_t MAC_TX_I, // Transmit bit from the MAC.
  input logic MAC_TX_VALID_I, // Transmit bit offered.
  output logic MAC_TX_READY_O, // Transmit buffer has room.
  output logic TRANSMIT_BIT_CLOCK_O, // 10 MHz transmit bit clock.
  output logic TX_POS_O, // Transmit pair, positive line.
  output logic TX_NEG_O, // Transmit pair, negative line.
  input logic RX_POS_I, // Receive pair, positive comparator.
  input logic RX_NEG_I, // Receive pair, negative comparator.
  input logic COLLISION_PAIR_POS_I, // Collision pair, positive comparator.
  input logic COLLISION_PAIR_NEG_I, // Collision pair, negative comparator.
  output mei_pkg::mei_rx_t MAC_RX_O, // Receive group to the MAC.
  output logic CODEC_TXEN_O, // Transmit enable on the codec pins.
  output logic CODEC_TXD_O, // Transmit NRZ data on the codec pins.
  output mei_pkg::mei_rx_t CODEC_RX_O, // Copy of the internal receive group; zero when bypassed.
  input mei_pkg::mei_rx_t EXT_RX_I // Receive group from an external codec.
);
  import mei_pkg::*;

  logic [SYNC_W-1:0] sync_q;
  logic bypass, idle_sel, osc_s, rx_pos_s, rx_neg_s, col_pos_s, col_neg_s;
  mei_rx_t ext_rx_s, int_rx;
  logic osc_prev, tick, transmit_bit_clock;
  mei_txw_t fifo_od, cur, next_cur;
  logic fifo_ov, pop;
  mei_enc_t state, next_state;
  logic line_lvl, next_lvl, col_sel;
  logic rx_valid, rx_last, rx_edge, crs, rxd, rxc;
  logic [7:0] since_edge, since_mid;
  logic [2:0] sq_cnt, col_cnt;
  logic col_last, col_edge, col_act;
  logic [7:0] col_since;

  mei_sync #(.W(SYNC_W)) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .d_i({CODEC_BYPASS_STRAP_I, IDLE_LEVEL_STRAP_I, OSCILLATOR_INPUT_I, RX_POS_I, RX_NEG_I,
          COLLISION_PAIR_POS_I, COLLISION_PAIR_NEG_I, EXT_RX_I}),
    .q_o(sync_q)
  );

  // Straps are followed continuously at their synchronised level.
  assign {bypass, idle_sel, osc_s, rx_pos_s, rx_neg_s, col_pos_s, col_neg_s} = sync_q[10:4];
  assign ext_rx_s = sync_q[3:0];
  assign tick = osc_s && !osc_prev;
  assign col_sel = bypass ? ext_rx_s.collision : col_act;

  mei_fifo #(.W($bits(mei_txw_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .in_data_i(MAC_TX_I),
    .in_valid_i(MAC_TX_VALID_I),
    .in_ready_o(MAC_TX_READY_O),
    .out_data_o(fifo_od),
    .out_valid_o(fifo_ov),
    .out_ready_i(pop)
  );

  // Every oscillator rising edge is a half-cell tick; the bit clock toggles on each.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      osc_prev <= 1'b0;
      transmit_bit_clock <= TXC_RST;
      OSCILLATOR_OUTPUT_O <= 1'b1;
    end
    else
    begin
      osc_prev <= osc_s;
      transmit_bit_clock <= transmit_bit_clock ^ tick;
      OSCILLATOR_OUTPUT_O <= !osc_s;
    end
  end
  assign TRANSMIT_BIT_CLOCK_O = transmit_bit_clock;

  // Encoder sequencing; a frame starts only on a bit-clock boundary so cells stay aligned.
  always_comb
  begin
    next_state = state;
    next_lvl = line_lvl;
    next_cur = cur;
    pop = 1'b0;
    unique case (state)
      ENC_IDLE:
        if (tick && transmit_bit_clock && fifo_ov)
        begin
          pop = 1'b1;
          next_cur = fifo_od;
          next_lvl = !fifo_od.bit_val;
          next_state = ENC_FIRST;
        end
      ENC_FIRST:
        if (tick && col_sel)
        begin
          next_lvl = 1'b1;
          next_state = cur.last ? ENC_TAIL : ENC_FLUSH;
        end
        else if (tick)
        begin
          next_lvl = cur.bit_val;
          next_state = ENC_SECOND;
        end
      ENC_SECOND:
        if (tick && col_sel)
        begin
          next_lvl = 1'b1;
          next_state = cur.last ? ENC_TAIL : ENC_FLUSH;
        end
        else if (tick && !cur.last && fifo_ov)
        begin
          pop = 1'b1;
          next_cur = fifo_od;
          next_lvl = !fifo_od.bit_val;
          next_state = ENC_FIRST;
        end
        else if (tick)
        begin
          // A last 1 is already high; a last 0 rises at the cell end.
          next_lvl = 1'b1;
          next_state = ENC_TAIL;
        end
      ENC_TAIL:
        if (tick)
        begin
          next_state = ENC_IDLE;
        end
      ENC_FLUSH:
        // The rest of the aborted frame is dropped; the MAC schedules the retry.
        if (fifo_ov)
        begin
          pop = 1'b1;
          if (fifo_od.last)
          begin
            next_state = ENC_TAIL;
          end
        end
    endcase
  end

  // Encoder state and the line; the line idles whenever the codec is bypassed.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      state <= ENC_IDLE;
      cur <= '0;
      line_lvl <= LINE_POS_RST;
      TX_POS_O <= LINE_POS_RST;
      TX_NEG_O <= LINE_NEG_RST;
      CODEC_TXEN_O <= 1'b0;
      CODEC_TXD_O <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cur <= next_cur;
      line_lvl <= next_lvl;
      if (bypass || next_state == ENC_IDLE)
      begin
        TX_POS_O <= !idle_sel;
        TX_NEG_O <= 1'b0;
      end
      else
      begin
        TX_POS_O <= next_lvl;
        TX_NEG_O <= !next_lvl;
      end
      CODEC_TXEN_O <= next_state == ENC_FIRST || next_state == ENC_SECOND;
      CODEC_TXD_O <= next_cur.bit_val;
    end
  end

  // Receive edges count only between valid differential levels; squelched input is ignored.
  assign rx_valid = {rx_pos_s, rx_neg_s} == LVL_HIGH || {rx_pos_s, rx_neg_s} == LVL_LOW;
  assign rx_edge = rx_valid && rx_pos_s != rx_last;

  // The first transition seen after a quiet gap opens a new squelch count.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      rx_last <= 1'b0;
      since_edge <= CNT_SAT;
      sq_cnt <= '0;
    end
    else
    begin
      rx_last <= rx_valid ? rx_pos_s : rx_last;
      since_edge <= rx_edge ? '0 : (since_edge == CNT_SAT ? since_edge : since_edge + CNT_ONE);
      if (crs && since_mid >= EOF_CYC)
      begin
        sq_cnt <= '0;
      end
      else if (rx_edge && !crs)
      begin
        sq_cnt <= since_edge <= SQ_GAP_CYC ? sq_cnt + EDGE_ONE : EDGE_ONE;
      end
    end
  end

  // A transition at least three quarters of a bit after the last mid-cell one is mid-cell.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      crs <= 1'b0;
      rxd <= 1'b0;
      rxc <= 1'b0;
      since_mid <= CNT_SAT;
    end
    else if (!crs)
    begin
      rxc <= 1'b0;
      since_mid <= CNT_SAT;
      if (rx_edge && since_edge <= SQ_GAP_CYC && sq_cnt == SQ_EDGES - EDGE_ONE)
      begin
        crs <= 1'b1;
        rxd <= rx_pos_s;
        rxc <= 1'b1;
        since_mid <= '0;
      end
    end
    else if (since_mid >= EOF_CYC)
    begin
      crs <= 1'b0;
      rxc <= 1'b0;
    end
    else if (rx_edge && since_mid >= MID_MIN_CYC)
    begin
      rxd <= rx_pos_s;
      rxc <= 1'b1;
      since_mid <= '0;
    end
    else
    begin
      since_mid <= since_mid + CNT_ONE;
      rxc <= since_mid + CNT_ONE >= RXC_HIGH_CYC ? 1'b0 : rxc;
    end
  end

  // Collision: repeated edges keep the indication up; it drops after a gap of two periods.
  assign col_edge = (col_pos_s != col_neg_s) && col_pos_s != col_last;
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      col_last <= 1'b0;
      col_cnt <= '0;
      col_since <= CNT_SAT;
      col_act <= 1'b0;
    end
    else
    begin
      col_last <= (col_pos_s != col_neg_s) ? col_pos_s : col_last;
      if (col_edge)
      begin
        col_since <= '0;
        col_cnt <= col_cnt == COL_EDGES ? col_cnt : col_cnt + EDGE_ONE;
        col_act <= col_act || col_cnt + EDGE_ONE >= COL_EDGES;
      end
      else if (col_since >= COL_HOLD_CYC)
      begin
        col_cnt <= '0;
        col_act <= 1'b0;
      end
      else
      begin
        col_since <= col_since + CNT_ONE;
      end
    end
  end

  // Receive group to the MAC comes from the selected codec; the copy pins show the internal one, or zero when bypassed.
  assign int_rx = '{clk: rxc, data: rxd, carrier: crs, collision: col_act};
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      MAC_RX_O <= '0;
      CODEC_RX_O <= '0;
    end
    else
    begin
      MAC_RX_O <= bypass ? ext_rx_s : int_rx;
      CODEC_RX_O <= bypass ? '0 : int_rx;
    end
  end

  AST_LINE_IDLE: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (bypass || next_state == ENC_IDLE) |=> TX_POS_O == !$past(idle_sel) && !TX_NEG_O)
    else $error("Line not at idle level.");
  AST_OBS_COPY: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !bypass |=> CODEC_RX_O == $past(int_rx) && MAC_RX_O == $past(int_rx))
    else $error("Internal receive group not copied.");
  AST_EXT_PASS: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    bypass |=> MAC_RX_O == $past(ext_rx_s) && CODEC_RX_O == '0)
    else $error("External receive group not passed.");
  AST_CELL_FIRST: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (pop && next_state == ENC_FIRST && !bypass) |=> TX_POS_O == !$past(fifo_od.bit_val))
    else $error("First half not inverted.");
  AST_CELL_MID: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (state == ENC_FIRST && tick && !col_sel && !bypass) |=> TX_POS_O == cur.bit_val ##0
    TX_POS_O != $past(TX_POS_O))
    else $error("No mid-cell transition.");
  AST_END_POS: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (state == ENC_TAIL && !bypass) |-> TX_POS_O && !TX_NEG_O)
    else $error("Frame did not end high.");
  AST_TXC_DIV: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    tick |=> TRANSMIT_BIT_CLOCK_O != $past(TRANSMIT_BIT_CLOCK_O) ##1
    $stable(TRANSMIT_BIT_CLOCK_O))
    else $error("Bit clock not a half of the oscillator.");
  AST_SQUELCH: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $rose(crs) |-> $past(rx_edge) && $past(sq_cnt) == SQ_EDGES - EDGE_ONE)
    else $error("Carrier without squelch qualification.");
  AST_EOF: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (crs && since_mid == EOF_CYC) |=> !crs ##1 !MAC_RX_O.carrier || bypass)
    else $error("End of frame not found in time.");
  AST_COL_STEADY: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (col_act && col_since < COL_HOLD_CYC) |=> col_act)
    else $error("Collision indication dropped early.");
  AST_ABORT: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    ((state == ENC_FIRST || state == ENC_SECOND) && tick && col_sel) |=>
    (state == ENC_FLUSH || state == ENC_TAIL) && !CODEC_TXEN_O)
    else $error("Transmission not aborted on collision.");

  CV_FRAME_END: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    state == ENC_SECOND ##1 state == ENC_TAIL);
  CV_ABORT: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) state == ENC_FLUSH);
  CV_RX_START: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) $rose(crs));
  CV_RX_END: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) $fell(crs));
endmodule

/* verification/mei_aui_model.sv */
`timescale 1ns/10ps
// Far-side transceiver: it drives the receive and collision pairs.
// A released pair sits at equal levels, which the receiver treats as squelch.
module mei_aui_model (
  output logic rx_pos_o, // Receive pair, positive line.
  output logic rx_neg_o, // Receive pair, negative line.
  output logic col_pos_o, // Collision pair, positive line.
  output logic col_neg_o // Collision pair, negative line.
);
  // Both pairs start released.
  initial
  begin
    {rx_pos_o, rx_neg_o} = 2'h0;
    {col_pos_o, col_neg_o} = 2'h0;
  end

  // Sends n cells, the bit at position n-1 first, then releases the pair.
  task automatic send(input logic [15:0] bits, input int n);
    logic b;
    for (int i = n - 1; i >= 0; i--)
    begin
      b = bits[i];
      {rx_pos_o, rx_neg_o} = {~b, b};
      #50;
      {rx_pos_o, rx_neg_o} = {b, ~b};
      #50;
    end
    {rx_pos_o, rx_neg_o} = 2'h0;
  endtask

  // Drives the 10 MHz collision signal for n full periods, then releases it.
  task automatic collide(input int n);
    repeat (n)
    begin
      {col_pos_o, col_neg_o} = 2'h2;
      #50;
      {col_pos_o, col_neg_o} = 2'h1;
      #50;
    end
    {col_pos_o, col_neg_o} = 2'h0;
  endtask
endmodule

/* verification/tb.sv */
`timescale 1ns/10ps
// Self-checking bench for the Manchester codec top level.
module tb;
  import mei_pkg::*;
  logic clk, rst, byp, idl, osc, osc_out, tx_v, tx_rdy, transmit_bit_clock, tx_p, tx_n;
  logic rx_p, rx_n, cd_p, cd_n, txen, txd, rx_ck_q;
  mei_txw_t tx_w;
  mei_rx_t mac_rx, cod_rx, ext_rx;
  logic [7:0] rx_sh;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  // System clock at 200 MHz.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Oscillator at 20 MHz, offset so that its edges never meet the clock's.
  initial
  begin
    osc = 1'b0;
    #1.3;
    forever #25 osc = ~osc;
  end

  mei_top u_dut (
    .SYS_CLK_I(clk), .SYS_RST_I(rst), .CODEC_BYPASS_STRAP_I(byp),
    .IDLE_LEVEL_STRAP_I(idl), .OSCILLATOR_INPUT_I(osc), .OSCILLATOR_OUTPUT_O(osc_out),
    .MAC_TX_I(tx_w), .MAC_TX_VALID_I(tx_v), .MAC_TX_READY_O(tx_rdy),
    .TRANSMIT_BIT_CLOCK_O(transmit_bit_clock), .TX_POS_O(tx_p), .TX_NEG_O(tx_n), .RX_POS_I(rx_p),
    .RX_NEG_I(rx_n), .COLLISION_PAIR_POS_I(cd_p), .COLLISION_PAIR_NEG_I(cd_n),
    .MAC_RX_O(mac_rx), .CODEC_TXEN_O(txen), .CODEC_TXD_O(txd), .CODEC_RX_O(cod_rx),
    .EXT_RX_I(ext_rx)
  );

  mei_aui_model u_aui (
    .rx_pos_o(rx_p), .rx_neg_o(rx_n), .col_pos_o(cd_p), .col_neg_o(cd_n)
  );

  // Recovered bits shift in on each rising receive clock while carrier is up.
  always @(posedge clk)
  begin
    rx_ck_q <= mac_rx.clk;
    if (mac_rx.clk && !rx_ck_q && mac_rx.carrier)
      rx_sh <= {rx_sh[6:0], mac_rx.data};
  end

  // A hang is cut short well above the few thousand cycles the run needs.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_vec(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_pair(input logic [1:0] e);
    chk_vec("transmit pair", {6'h0, e}, {6'h0, tx_p, tx_n});
  endtask

  // Waits n falling edges, where every output has settled.
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Offers one word from a rising edge and returns at the edge that takes it.
  task automatic push(input logic b, input logic l);
    tx_v <= 1'b1;
    tx_w <= {b, l};
    do
      @(negedge clk);
    while (tx_rdy !== 1'b1);
    @(posedge clk);
  endtask

  task automatic send_frame(input logic [15:0] bits, input int n);
    @(posedge clk);
    for (int i = n - 1; i >= 0; i--)
      push(bits[i], i == 0);
    tx_v <= 1'b0;
  endtask

  // The bound keeps a dead encoder from hanging the run.
  task automatic wait_txen(input logic v, input int lim);
    int k;
    k = 0;
    while (txen !== v && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    chk_bit("codec transmit enable", v, txen);
  endtask

  task automatic straps(input logic b, input logic i);
    @(posedge clk);
    byp <= b;
    idl <= i;
    w(10);
  endtask

  task automatic t_reset();
    chk_pair(2'h2);
    chk_bit("ready at reset", 1'b1, tx_rdy);
    chk_bit("bit clock at reset", 1'b0, transmit_bit_clock);
    chk_vec("receive groups at reset", 8'h00, {mac_rx, cod_rx});
    chk_bit("enable at reset", 1'b0, txen);
    chk_bit("oscillator output at reset", 1'b1, osc_out);
  endtask

  // Eighty cycles hold exactly eight bit clock and sixteen feedback changes.
  task automatic t_clock();
    logic c0;
    logic o0;
    int nc;
    int no;
    nc = 0;
    no = 0;
    c0 = transmit_bit_clock;
    o0 = osc_out;
    repeat (80)
    begin
      w(1);
      nc += (transmit_bit_clock !== c0);
      no += (osc_out !== o0);
      c0 = transmit_bit_clock;
      o0 = osc_out;
    end
    chk_vec("bit clock changes", 8'h08, nc[7:0]);
    chk_vec("oscillator output changes", 8'h10, no[7:0]);
  endtask

  // Sends a frame and samples the pair in the middle of every half cell.
  task automatic t_tx(input logic [15:0] bits, input int n);
    logic b;
    logic ip;
    ip = ~idl;
    fork
      send_frame(bits, n);
      begin
        wait_txen(1'b1, 200);
        w(4);
        for (int i = n - 1; i >= 0; i--)
        begin
          b = bits[i];
          chk_bit("codec data", b, txd);
          chk_pair(byp ? {ip, 1'b0} : {~b, b});
          w(10);
          chk_pair(byp ? {ip, 1'b0} : {b, ~b});
          w(10);
        end
        chk_pair(byp ? {ip, 1'b0} : 2'h2);
        w(20);
        chk_pair({ip, 1'b0});
        chk_bit("enable after frame", 1'b0, txen);
      end
    join
  endtask

  // The thirteen recovered bits push any earlier content out of the byte register.
  task automatic t_rx();
    u_aui.send(16'hAAC5, 16);
    chk_bit("carrier at last bit", 1'b1, mac_rx.carrier);
    chk_bit("copied carrier", 1'b1, cod_rx.carrier);
    chk_vec("recovered byte", 8'hC5, rx_sh);
    w(30);
    chk_bit("carrier after frame", 1'b0, mac_rx.carrier);
    u_aui.send(16'h0002, 2);
    w(8);
    chk_bit("carrier after short burst", 1'b0, mac_rx.carrier);
  endtask

  task automatic t_col();
    int lows;
    lows = 0;
    fork
      u_aui.collide(20);
      begin
        w(40);
        repeat (120)
        begin
          lows += (mac_rx.collision !== 1'b1);
          w(1);
        end
      end
    join
    chk_vec("collision gaps", 8'h00, lows[7:0]);
    w(60);
    chk_bit("collision after release", 1'b0, mac_rx.collision);
  endtask

  // A collision early in a long frame must cut it short and empty the buffer.
  task automatic t_abort();
    fork
      send_frame(16'hFFFF, 16);
      begin
        wait_txen(1'b1, 200);
        w(40);
        u_aui.collide(4);
        w(60);
        chk_bit("enable after collision", 1'b0, txen);
        chk_pair({~idl, 1'b0});
        chk_bit("ready after abort", 1'b1, tx_rdy);
      end
    join
    w(60);
  endtask

  // Offers words every cycle for 36 cycles; only one or two leave meanwhile.
  task automatic t_fill();
    int k;
    logic seen;
    k = 0;
    seen = 1'b0;
    @(posedge clk);
    tx_v <= 1'b1;
    tx_w <= {1'b0, 1'b0};
    repeat (36)
    begin
      @(negedge clk);
      if (tx_rdy === 1'b1)
        k++;
      else
        seen = 1'b1;
      @(posedge clk);
    end
    push(1'b1, 1'b1);
    tx_v <= 1'b0;
    chk_bit("refusal seen", 1'b1, seen);
    chk_bit("accepted count in range", 1'b1, k >= 32 && k <= 34);
    wait_txen(1'b0, 1200);
    chk_bit("ready when drained", 1'b1, tx_rdy);
  endtask

  // A collision from the external codec must cut a frame short while bypassed.
  task automatic t_byp_abort();
    fork
      send_frame(16'hFFFF, 16);
      begin
        wait_txen(1'b1, 200);
        w(40);
        @(posedge clk);
        ext_rx <= 4'h1;
        w(60);
        chk_bit("bypassed collision", 1'b1, mac_rx.collision);
        chk_bit("enable after external collision", 1'b0, txen);
        chk_bit("ready after external abort", 1'b1, tx_rdy);
        @(posedge clk);
        ext_rx <= 4'h0;
      end
    join
    w(20);
  endtask

  task automatic t_byp_rx();
    @(posedge clk);
    ext_rx <= 4'hA;
    w(10);
    chk_vec("bypassed receive group", 8'h0A, {4'h0, mac_rx});
    chk_vec("copy when bypassed", 8'h00, {4'h0, cod_rx});
    @(posedge clk);
    ext_rx <= 4'h0;
  endtask

  // Main sequence: reset for five edges, then each scenario in turn.
  initial
  begin
    rst = 1'b1;
    byp = 1'b0;
    idl = 1'b0;
    tx_v = 1'b0;
    tx_w = 2'h0;
    ext_rx = 4'h0;
    w(5);
    t_reset();
    @(posedge clk);
    rst <= 1'b0;
    w(10);
    t_clock();
    t_tx(16'h00B4, 8);
    t_tx(16'h004B, 8);
    t_rx();
    t_col();
    t_abort();
    t_fill();
    straps(1'b0, 1'b1);
    t_tx(16'h0035, 6);
    straps(1'b1, 1'b0);
    t_tx(16'h0096, 8);
    t_byp_abort();
    t_byp_rx();
    summarize();
  end
endmodule
